// ### src/limit_homing_pkg.sv
/*
  Shared constants and carrier types for the limit-switch, homing and
  step/direction block.
  Assumes one 50 MHz system clock and a simple strobe register port.
*/
`default_nettype none
package limit_homing_pkg;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] PINCFG_ADDR = 8'h04;
  localparam logic [7:0] SPEED_ADDR = 8'h08;
  localparam logic [7:0] CMD_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] POS_ADDR = 8'h14;
  localparam logic [7:0] TARGET_ADDR = 8'h18;
  localparam logic [7:0] DRVCFG_ADDR = 8'h1c;
  // ==========================================================
  // Control register fields
  localparam int CTRL_PASS_BIT = 0;
  localparam int CTRL_AUTOEN_BIT = 1;
  localparam int CTRL_AUTODIR_BIT = 2;
  localparam int CTRL_DEENERG_BIT = 3;
  // Pin config: per pin 4 bits {analog, pullup, polarity, fwd/rev},
  // plus a limit enable bit per pin at 20+i
  localparam int PINCFG_ENA_BASE = 20;
  localparam int PIN_FIELD_W = 4;
  // Command register bits
  localparam int CMD_HOME_REV_BIT = 0;
  localparam int CMD_HOME_FWD_BIT = 1;
  localparam int CMD_GOTO_BIT = 2;
  localparam int CMD_CONFIRM_BIT = 3;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SPEED_RESET = 32'h0010_0010;
  localparam logic [31:0] DRVCFG_RESET = 32'h0000_0000;
  // Limit status encoding
  localparam logic [1:0] LIM_NONE = 2'h0;
  localparam logic [1:0] LIM_FWD = 2'h1;
  localparam logic [1:0] LIM_REV = 2'h2;
  localparam logic [1:0] LIM_BOTH = 2'h3;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MOVE = 3'b001,
    ST_SEEK = 3'b010,
    ST_BACK = 3'b011
  } motion_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Outward step/direction pins
  typedef struct packed {
    logic step;
    logic dir;
    logic oe;
  } stepdir_out_t;
endpackage
`default_nettype wire

// ### src/limit_switch_homing_stepdir.sv
/*
  Limit switches, homing sequencer and step/direction routing for a
  stepper controller.
  Assumes inputs synchronous to ref_clk except the limit pins, which are
  synchronised here; pull resistors are realised by the pad ring.
*/
// The register offsets and the address-and-strobe port were decided locally.
// Behaviour
// - One driver step per step-input rising edge
// - Step and direction inputs weakly pulled low in pass-through
// - Pass-through disables limiting and position tracking
// - Driver settings still reachable in pass-through
// - Other modes drive step/direction as outputs
// - Missing supply flags error, no driving
// - Each control pin configurable forward/reverse limit
// - Forward limit blocks positive, reverse negative
// - Per-pin polarity: set means high active
// - Analog option ignored for limits
// - Any active pin activates its direction
// - Clock/data pulls selectable, serial pins pulled
// - Limit status: none, forward, reverse, both
// - Reverse homing seeks reverse, backs forward
// - Forward homing seeks forward, backs reverse
// - Homing end zeroes position, resumes normal
// - Separate approach and back-off speeds
// - Auto homing on position command when uncertain
// - Setting selects auto homing direction
// - Keep position-uncertain flag
`default_nettype none
module limit_switch_homing_stepdir #(
  parameter int NPINS = 5,
  parameter int SPEED_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire limit_homing_pkg::reg_req_t regReq,
  output logic [31:0] regRdata,
  // External step/direction inputs (pass-through)
  input wire logic stepIn,
  input wire logic dirIn,
  // Step/direction toward driver and external pins
  output limit_homing_pkg::stepdir_out_t extStepDir,
  output logic drvStep,
  output logic drvDir,
  output logic drvEnable,
  output logic [7:0] drvCfg,
  // Input pad pulls
  output logic stepDirPullDown,
  output logic [NPINS-1:0] pinPullUp,
  // Limit pins and supply sense
  input wire logic [NPINS-1:0] ctrlPin,
  input wire logic mainSupplyOk,
  // Status
  output logic lowSupplyError,
  output logic [1:0] limitStatus,
  output logic homingActive
);
  import limit_homing_pkg::*;

  initial begin
    if (NPINS != 5 || SPEED_W < 2 || SPEED_W > 16) begin
      $error("Unsupported parameter values");
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] ctrl;          // Mode and auto homing
    logic [31:0] pinCfg;        // Limit pin setup
    logic [31:0] speed;         // Toward low half, away high half
    logic [31:0] drv;           // Driver current/decay/step mode
    logic signed [31:0] pos;    // Current position
    logic signed [31:0] target; // Target position
    logic uncertain;            // Position not confirmed
    logic homeDir;              // 1 forward homing
    motion_state_t st;          // Sequencer state
    logic [SPEED_W-1:0] tick;   // Step period counter
    logic stepPulse;            // Outgoing step level
    logic stepDir;              // Outgoing direction
    logic [NPINS-1:0] sync1;    // Synchroniser first stage
    logic [NPINS-1:0] sync2;    // Synchroniser second stage
    logic [31:0] rdata;         // Read data
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  // Decoded limit levels
  logic [NPINS-1:0] pinActive;
  logic [NPINS-1:0] pinFwd;
  logic [NPINS-1:0] pinRev;
  logic limFwd;
  logic limRev;
  logic haveFwd;
  logic haveRev;
  logic passMode;

  // ==========================================================
  // Per-pin limit decode
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      // Polarity bit picks active level; analog bit is not read
      assign pinActive[gi] = ~(cur_ff.sync2[gi] ^
        cur_ff.pinCfg[gi*PIN_FIELD_W+1]);
      assign pinFwd[gi] = cur_ff.pinCfg[PINCFG_ENA_BASE+gi] &
        cur_ff.pinCfg[gi*PIN_FIELD_W];
      assign pinRev[gi] = cur_ff.pinCfg[PINCFG_ENA_BASE+gi] &
        ~cur_ff.pinCfg[gi*PIN_FIELD_W];
      // Pins 0,1 are clock/data: selectable; 2,3 serial: always on
      if (gi < 2) begin : g_sel
        assign pinPullUp[gi] = cur_ff.pinCfg[gi*PIN_FIELD_W+2];
      end else if (gi < 4) begin : g_fix
        assign pinPullUp[gi] = 1'b1;
      end else begin : g_none
        assign pinPullUp[gi] = 1'b0;
      end
    end
  endgenerate

  // Any assigned pin active makes its direction active
  assign limFwd = |(pinActive & pinFwd);
  assign limRev = |(pinActive & pinRev);
  assign haveFwd = |pinFwd;
  assign haveRev = |pinRev;
  assign passMode = cur_ff.ctrl[CTRL_PASS_BIT];

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic moveFwd;
    logic [SPEED_W-1:0] period;
    logic stepNow;
    moveFwd = 1'b0;
    period = '0;
    stepNow = 1'b0;
    nxt_cur = cur_ff;
    nxt_cur.sync1 = ctrlPin;
    nxt_cur.sync2 = cur_ff.sync1;
    nxt_cur.rdata = '0;

    // Register writes
    if (regReq.wr) begin
      unique case (regReq.addr)
        CTRL_ADDR: nxt_cur.ctrl = regReq.wdata;
        PINCFG_ADDR: nxt_cur.pinCfg = regReq.wdata;
        SPEED_ADDR: nxt_cur.speed = regReq.wdata;
        DRVCFG_ADDR: nxt_cur.drv = regReq.wdata;
        TARGET_ADDR: nxt_cur.target = regReq.wdata;
        default: ;
      endcase
    end

    // Register reads, answer next cycle
    if (regReq.rd) begin
      unique case (regReq.addr)
        CTRL_ADDR: nxt_cur.rdata = cur_ff.ctrl;
        PINCFG_ADDR: nxt_cur.rdata = cur_ff.pinCfg;
        SPEED_ADDR: nxt_cur.rdata = cur_ff.speed;
        DRVCFG_ADDR: nxt_cur.rdata = cur_ff.drv;
        TARGET_ADDR: nxt_cur.rdata = cur_ff.target;
        POS_ADDR: nxt_cur.rdata = cur_ff.pos;
        STATUS_ADDR: nxt_cur.rdata = {25'h0, cur_ff.st, cur_ff.uncertain,
          ~mainSupplyOk, limitStatus};
        default: nxt_cur.rdata = '0;
      endcase
    end

    // Confirm position externally
    if (regReq.wr && regReq.addr == CMD_ADDR &&
        regReq.wdata[CMD_CONFIRM_BIT]) begin
      nxt_cur.uncertain = 1'b0;
    end

    // Step timing: toward speed while seeking, away speed backing off
    period = (cur_ff.st == ST_BACK) ? cur_ff.speed[16+:SPEED_W]
                                    : cur_ff.speed[0+:SPEED_W];
    nxt_cur.stepPulse = 1'b0;
    if (cur_ff.tick >= period) begin
      nxt_cur.tick = '0;
      stepNow = (period != '0);
    end else begin
      nxt_cur.tick = cur_ff.tick + 1'b1;
    end

    // Sequencer
    unique case (cur_ff.st)
      ST_IDLE: begin
        nxt_cur.tick = '0;
        if (regReq.wr && regReq.addr == CMD_ADDR && !passMode) begin
          if (regReq.wdata[CMD_HOME_REV_BIT] && haveRev) begin
            nxt_cur.st = ST_SEEK;
            nxt_cur.homeDir = 1'b0;
          end else if (regReq.wdata[CMD_HOME_FWD_BIT] && haveFwd) begin
            nxt_cur.st = ST_SEEK;
            nxt_cur.homeDir = 1'b1;
          end else if (regReq.wdata[CMD_GOTO_BIT]) begin
            // Uncertain position with auto homing: home first
            if (cur_ff.uncertain && cur_ff.ctrl[CTRL_AUTOEN_BIT] &&
                (cur_ff.ctrl[CTRL_AUTODIR_BIT] ? haveFwd : haveRev)) begin
              nxt_cur.st = ST_SEEK;
              nxt_cur.homeDir = cur_ff.ctrl[CTRL_AUTODIR_BIT];
            end else begin
              nxt_cur.st = ST_MOVE;
            end
          end
        end
      end
      ST_MOVE: begin
        moveFwd = (cur_ff.target > cur_ff.pos);
        if (cur_ff.target == cur_ff.pos ||
            (moveFwd && limFwd) || (!moveFwd && limRev)) begin
          nxt_cur.st = ST_IDLE;
        end else if (stepNow) begin
          nxt_cur.stepPulse = 1'b1;
          nxt_cur.stepDir = moveFwd;
          nxt_cur.pos = moveFwd ? cur_ff.pos + 32'sd1
                                : cur_ff.pos - 32'sd1;
        end
      end
      ST_SEEK: begin
        // Travel toward the homing limit until it asserts
        if (cur_ff.homeDir ? limFwd : limRev) begin
          nxt_cur.st = ST_BACK;
          nxt_cur.tick = '0;
        end else if (stepNow) begin
          nxt_cur.stepPulse = 1'b1;
          nxt_cur.stepDir = cur_ff.homeDir;
        end
      end
      ST_BACK: begin
        // Back away until the limit releases, then zero
        if (!(cur_ff.homeDir ? limFwd : limRev)) begin
          nxt_cur.st = ST_IDLE;
          nxt_cur.pos = '0;
          nxt_cur.target = '0;
          nxt_cur.uncertain = 1'b0;
        end else if (stepNow) begin
          nxt_cur.stepPulse = 1'b1;
          nxt_cur.stepDir = ~cur_ff.homeDir;
        end
      end
      default: nxt_cur.st = ST_IDLE;
    endcase

    // Pass-through or missing supply stops internal motion
    if (passMode || !mainSupplyOk) begin
      nxt_cur.st = ST_IDLE;
      nxt_cur.stepPulse = 1'b0;
    end
    // Losing supply makes the position uncertain
    if (!mainSupplyOk) begin
      nxt_cur.uncertain = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '{ctrl: CTRL_RESET, pinCfg: 32'h0, speed: SPEED_RESET,
        drv: DRVCFG_RESET, pos: 32'sh0, target: 32'sh0, uncertain: 1'b1,
        homeDir: 1'b0, st: ST_IDLE, tick: '0, stepPulse: 1'b0,
        stepDir: 1'b0, sync1: '0, sync2: '0, rdata: 32'h0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================
  // Outputs
  // Pass-through routes pins straight to the driver's edge input
  assign drvStep = passMode ? stepIn : 1'b0;
  assign drvDir = passMode ? dirIn : 1'b0;
  assign stepDirPullDown = passMode;
  assign extStepDir.step = cur_ff.stepPulse;
  assign extStepDir.dir = cur_ff.stepDir;
  assign extStepDir.oe = ~passMode & mainSupplyOk;
  assign drvEnable = mainSupplyOk & ~cur_ff.ctrl[CTRL_DEENERG_BIT];
  assign drvCfg = cur_ff.drv[7:0];
  assign lowSupplyError = ~mainSupplyOk;
  assign limitStatus = {limRev, limFwd};
  assign homingActive = (cur_ff.st == ST_SEEK) || (cur_ff.st == ST_BACK);
  assign regRdata = cur_ff.rdata;
endmodule
`default_nettype wire

// ### test/limit_homing_sva.sv
/* Checker for the limit and homing block.
   Assumes binding to the top module; sees its ports only. */
`default_nettype none
module limit_homing_chk
  import limit_homing_pkg::*;
#(parameter int NPINS = 5) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Watched inputs
  input wire logic stepIn,
  input wire logic dirIn,
  input wire logic mainSupplyOk,
  // Watched outputs
  input wire stepdir_out_t extStepDir,
  input wire logic drvStep,
  input wire logic drvDir,
  input wire logic drvEnable,
  input wire logic stepDirPullDown,
  input wire logic [NPINS-1:0] pinPullUp,
  input wire logic lowSupplyError
);
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // A step is one high cycle then low
  sequence stepPulse;
    extStepDir.step ##1 !extStepDir.step;
  endsequence
  chk_step_pulse: assert property (extStepDir.step |-> stepPulse)
    else $error("step pulse too long");
  chk_low_flag: assert property (lowSupplyError == !mainSupplyOk)
    else $error("supply flag wrong");
  chk_supply_off: assert property (!mainSupplyOk |-> !extStepDir.oe)
    else $error("driving without supply");
  chk_pass_follow: assert property (stepDirPullDown |->
    drvStep == stepIn && drvDir == dirIn) else $error("no pass-through");
  chk_out_quiet: assert property (!stepDirPullDown |->
    !drvStep && !drvDir) else $error("driver pins leak");
  chk_oe_mode: assert property (extStepDir.oe ==
    (!stepDirPullDown && mainSupplyOk)) else $error("output enable wrong");
  chk_enable_supply: assert property (drvEnable |-> mainSupplyOk)
    else $error("enabled without supply");
  chk_pass_still: assert property (stepDirPullDown &&
    $past(stepDirPullDown) |-> !extStepDir.step) else $error("steps in pass");
  chk_pull_fixed: assert property (pinPullUp[3:2] == 2'h3 &&
    !pinPullUp[4]) else $error("serial pulls wrong");
endmodule
bind limit_switch_homing_stepdir limit_homing_chk #(.NPINS(NPINS)) chk_inst (
  .ref_clk(ref_clk), .rstn(rstn), .stepIn(stepIn), .dirIn(dirIn),
  .mainSupplyOk(mainSupplyOk), .extStepDir(extStepDir),
  .drvStep(drvStep), .drvDir(drvDir), .drvEnable(drvEnable),
  .stepDirPullDown(stepDirPullDown), .pinPullUp(pinPullUp),
  .lowSupplyError(lowSupplyError));
`default_nettype wire

// ### test/limit_switch_model.sv
/* Axis with a reverse limit switch at its low end.
   Assumes step pulses and direction from the block's output pins. */
`default_nettype none
module limit_switch_model #(parameter int TRIP = -3) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Step/direction from the block
  input wire limit_homing_pkg::stepdir_out_t sd,
  // Switch contact, high when pressed
  output logic revPin
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos; // Carriage position in steps
  // Move only on enabled step pulses
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) pos <= 0;
    else if (sd.step && sd.oe) pos <= sd.dir ? pos + 1 : pos - 1;
  end
  assign revPin = (pos <= TRIP);
endmodule
`default_nettype wire

// ### test/limit_switch_homing_stepdir_bench.sv
/* Self-checking bench for the limit and homing block.
   Assumes the switch model on pin 0 and register reads checked late. */
`default_nettype none
module limit_switch_homing_stepdir_bench;
  import limit_homing_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic ref_clk = 0, rstn = 0, stepIn = 0, dirIn = 0, mainSupplyOk = 1;
  reg_req_t regReq = '0;
  logic [4:0] tbPins = '0, pinPullUp;
  logic revPin, drvStep, drvDir, drvEnable, stepDirPullDown;
  logic lowSupplyError, homingActive, rdLag = 0, lastDir = 0;
  logic [31:0] regRdata, expQ[$];
  logic [7:0] drvCfg;
  logic [1:0] limitStatus;
  stepdir_out_t extStepDir;
  int failures = 0, comparisons = 0, cyc = 0, lastCyc = 0;
  int revSteps = 0, fwdSteps = 0;
  wire logic [4:0] ctrlPin = {tbPins[4:1], tbPins[0] | revPin};
  always #10 ref_clk = ~ref_clk;
  limit_switch_homing_stepdir limit_switch_homing_stepdir_inst (
    .ref_clk(ref_clk), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
    .stepIn(stepIn), .dirIn(dirIn), .extStepDir(extStepDir),
    .drvStep(drvStep), .drvDir(drvDir), .drvEnable(drvEnable),
    .drvCfg(drvCfg), .stepDirPullDown(stepDirPullDown),
    .pinPullUp(pinPullUp), .ctrlPin(ctrlPin), .mainSupplyOk(mainSupplyOk),
    .lowSupplyError(lowSupplyError), .limitStatus(limitStatus),
    .homingActive(homingActive));
  limit_switch_model limit_switch_model_inst (
    .ref_clk(ref_clk), .rstn(rstn), .sd(extStepDir), .revPin(revPin));
  // ==========================================================
  // Tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) regReq <= '0;
  endtask
  // Note the expected word, the watcher compares it
  task rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge ref_clk) regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk) regReq <= '0;
  endtask
  // Run one homing pass against the switch model
  task home(input logic [31:0] cmd, input int nRev);
    revSteps = 0;
    fwdSteps = 0;
    lastCyc = 0;
    wr(CMD_ADDR, cmd);
    repeat (2) @(posedge ref_clk);
    check(homingActive, 1);
    for (int i = 0; i < 2000 && homingActive; i++) @(posedge ref_clk);
    check(revSteps, nRev);
    check(fwdSteps, 1);
    rd(POS_ADDR, 32'h0);
    $display("homing pass done");
  endtask
  task test_done;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Watcher: late read data, step spacing, timeout
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rdLag) check(regRdata, expQ.pop_front());
    rdLag <= regReq.rd;
    if (extStepDir.step && homingActive) begin
      if (extStepDir.dir) fwdSteps++;
      else revSteps++;
      if (lastCyc != 0 && extStepDir.dir === lastDir)
        check(cyc - lastCyc, extStepDir.dir ? 4 : 6);
      lastCyc <= cyc;
      lastDir <= extStepDir.dir;
    end
    if (cyc > 20000) begin
      failures++;
      test_done();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [4:0] p;
    void'($urandom(32'he41c));
    repeat (12) @(posedge ref_clk);
    rstn <= 1;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(SPEED_ADDR, SPEED_RESET);
    rd(STATUS_ADDR, 32'h8);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    wr(CMD_ADDR, 32'h1);
    repeat (4) @(posedge ref_clk);
    check(homingActive, 0);
    $display("reset test done");
    wr(PINCFG_ADDR, 32'h0070_0b12);
    check(pinPullUp, 5'h0c);
    repeat (8) begin
      p = 5'($urandom);
      @(posedge ref_clk) tbPins <= p;
      repeat (4) @(posedge ref_clk);
      check(limitStatus, {p[0], !p[1] | p[2]});
      rd(STATUS_ADDR, {28'h2, p[0], !p[1] | p[2]});
    end
    $display("limit test done");
    @(posedge ref_clk) tbPins <= 5'h02;
    wr(SPEED_ADDR, 32'h0003_0005);
    home(32'h1, 3);
    @(posedge ref_clk) mainSupplyOk <= 0;
    repeat (2) @(posedge ref_clk);
    check(lowSupplyError, 1);
    check(extStepDir.oe, 0);
    rd(STATUS_ADDR, 32'hc);
    @(posedge ref_clk) mainSupplyOk <= 1;
    $display("supply test done");
    wr(CTRL_ADDR, 32'h2);
    wr(TARGET_ADDR, 32'h0);
    // Carriage rests one step above the trip point after the first pass
    home(32'h4, 1);
    wr(CTRL_ADDR, 32'h9);
    wr(DRVCFG_ADDR, 32'h5a);
    rd(DRVCFG_ADDR, 32'h5a);
    check(drvCfg, 8'h5a);
    check(drvEnable, 0);
    check(stepDirPullDown, 1);
    repeat (6) begin
      @(posedge ref_clk) {stepIn, dirIn} <= 2'($urandom);
      @(negedge ref_clk) check({drvStep, drvDir}, {stepIn, dirIn});
    end
    wr(CMD_ADDR, 32'h1);
    repeat (3) @(posedge ref_clk);
    check(homingActive, 0);
    $display("pass-through test done");
    test_done();
  end
endmodule
`default_nettype wire
